//--- bench/cfl_lock_setup_asserts.sv
`timescale 1ns/1ps
module cfl_lock_setup_asserts import cfl_pkg::*; (
   input wire logic clk,
   input wire logic rst,
   input wire logic sdc_in,
   input wire logic sda_oe,
   input wire logic signal_detect,
   input wire logic meas_valid,
   input wire logic cdr_lock,
   input wire logic cdr_in_reset,
   input wire logic lock_group,
   input wire logic [CAP_WIDTH-1:0] coarse_vco_capacitor_setting,
   input wire logic false_lock_det_en,
   input wire logic ref_assist_en
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   a_ref_mode_default: assert property ($fell(rst) |-> ref_assist_en)
      else $error("reference assist off after reset");
   a_false_lock_default: assert property ($fell(rst) |-> !false_lock_det_en)
      else $error("false lock detector enabled after reset");
   a_lock_on_measure: assert property (
      $rose(cdr_lock) |-> $past(meas_valid) && $past(signal_detect))
      else $error("lock without a valid measurement");
   a_lock_drops_on_loss: assert property ($fell(signal_detect) |-> ##[1:2] !cdr_lock)
      else $error("lock held after signal loss");
   a_restart_on_release: assert property ($fell(cdr_in_reset) |-> ##[1:3]
      (!cdr_lock && !lock_group && coarse_vco_capacitor_setting == '0))
      else $error("tuning did not restart after cdr reset release");
   // a step request is registered once before the tuner moves, hence depth two
   a_cap_single_step: assert property (
      $changed(coarse_vco_capacitor_setting) && coarse_vco_capacitor_setting != '0
      |-> $past(meas_valid, 2) && coarse_vco_capacitor_setting ==
      CAP_WIDTH'($past(coarse_vco_capacitor_setting) + 1))
      else $error("coarse capacitor moved other than one step");
   a_sda_on_clock_low: assert property ($changed(sda_oe) |-> !sdc_in && !$past(sdc_in))
      else $error("data line changed while serial clock high");
   a_cfg_on_clock_low: assert property (
      $changed({false_lock_det_en, ref_assist_en, cdr_in_reset}) |-> !sdc_in)
      else $error("register field changed outside a write");
endmodule
bind cfl_lock_setup cfl_lock_setup_asserts cfl_lock_setup_asserts_inst (
   .clk(clk), .rst(rst), .sdc_in(sdc_in), .sda_oe(sda_oe), .signal_detect(signal_detect),
   .meas_valid(meas_valid), .cdr_lock(cdr_lock), .cdr_in_reset(cdr_in_reset),
   .lock_group(lock_group), .coarse_vco_capacitor_setting(coarse_vco_capacitor_setting),
   .false_lock_det_en(false_lock_det_en), .ref_assist_en(ref_assist_en)
);

//--- bench/cfl_smb_host.sv
`timescale 1ns/1ps
module cfl_smb_host #(
   parameter logic [6:0] SMB_ADDR = 7'h18
) (
   input wire logic clk,
   input wire logic sda_line,
   output logic sdc,
   output logic sda_drv
);
   int nacks = 0;
   initial begin
      sdc = 1'b1;
      sda_drv = 1'b1;
   end
   // every phase spans several samples so the device sees each edge alone
   task automatic w(input logic c, input logic d, input int n);
      sdc <= c;
      sda_drv <= d;
      repeat (n) @(posedge clk);
   endtask
   task automatic start;
      w(1'b0, sda_drv, 2);
      w(1'b0, 1'b1, 2);
      w(1'b1, 1'b1, 4);
      w(1'b1, 1'b0, 4);
   endtask
   task automatic stop;
      w(1'b0, sda_drv, 2);
      w(1'b0, 1'b0, 2);
      w(1'b1, 1'b0, 4);
      w(1'b1, 1'b1, 4);
   endtask
   // data only moves while the clock is low, or it would read as start or stop
   task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         w(1'b0, sda_drv, 2);
         w(1'b0, tx[i], 2);
         w(1'b1, tx[i], 2);
         rx[i] = sda_line;
         repeat (2) @(posedge clk);
      end
   endtask
   task automatic send(input logic [7:0] b);
      logic [8:0] r;
      xfer({b, 1'b1}, r);
      nacks += int'(r[0]);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      start();
      send({SMB_ADDR, 1'b0});
      send(a);
      send(d);
      stop();
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      logic [8:0] r;
      start();
      send({SMB_ADDR, 1'b0});
      send(a);
      start();
      send({SMB_ADDR, 1'b1});
      xfer(9'h1ff, r);
      d = r[8:1];
      stop();
   endtask
   // master acks the first byte and nacks the second
   task automatic rd2(input logic [7:0] a, output logic [7:0] d0, output logic [7:0] d1);
      logic [8:0] r;
      start();
      send({SMB_ADDR, 1'b0});
      send(a);
      start();
      send({SMB_ADDR, 1'b1});
      xfer(9'h1fe, r);
      d0 = r[8:1];
      xfer(9'h1ff, r);
      d1 = r[8:1];
      stop();
   endtask
   // rates in sixteenths of a gbps keep the count integral
   task automatic configure(input logic [7:0] std, input int r0, input int r1,
                            input logic [7:0] tol);
      logic [14:0] c0;
      logic [14:0] c1;
      c0 = 15'(r0 * 1280 / 16);
      c1 = 15'(r1 * 1280 / 16);
      wr(8'hff, 8'h01);
      wr(8'h36, 8'h30);
      wr(8'h2f, std);
      wr(8'h60, c0[7:0]);
      wr(8'h61, {1'b1, c0[14:8]});
      wr(8'h62, c1[7:0]);
      wr(8'h63, {1'b1, c1[14:8]});
      wr(8'h64, tol);
      wr(8'h0a, 8'h0c);
      wr(8'h0a, 8'h00);
   endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench import cfl_pkg::*;;
   logic clk, rst, signal_detect, meas_valid, sdc, sda_drv, sda_oe, sda_out;
   logic cdr_lock, cdr_in_reset, lock_group, false_lock_det_en, ref_assist_en;
   logic [CNT_WIDTH-1:0] meas_count;
   logic [1:0] divider_exp;
   logic [CAP_WIDTH-1:0] cap;
   logic [7:0] rd, rd_next;
   wire logic sda_line = sda_drv & (sda_oe ? sda_out : 1'b1);
   int n_mismatch = 0;
   int n_checks = 0;
   cfl_lock_setup cfl_lock_setup_inst (
      .clk(clk), .rst(rst), .sdc_in(sdc), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
      .signal_detect(signal_detect), .meas_count(meas_count), .meas_valid(meas_valid),
      .cdr_lock(cdr_lock), .cdr_in_reset(cdr_in_reset), .lock_group(lock_group),
      .divider_exp(divider_exp), .coarse_vco_capacitor_setting(cap),
      .false_lock_det_en(false_lock_det_en), .ref_assist_en(ref_assist_en)
   );
   cfl_smb_host cfl_smb_host_inst (.clk(clk), .sda_line(sda_line), .sdc(sdc), .sda_drv(sda_drv));
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic st(input logic lk, input logic g, input logic [1:0] dx, input int cp);
      chk("cdr_lock", 16'(lk), 16'(cdr_lock));
      chk("lock_group", 16'(g), 16'(lock_group));
      chk("divider_exp", 16'(dx), 16'(divider_exp));
      chk("cap", 16'(cp), 16'(cap));
   endtask
   task automatic meas(input int c);
      meas_count <= 15'(c);
      meas_valid <= 1'b1;
      @(posedge clk);
      meas_valid <= 1'b0;
      repeat (2) @(posedge clk);
   endtask
   task automatic t_reset_values;
      logic [7:0] a [10] = '{8'h0a, 8'h2f, 8'h36, 8'h60, 8'h61, 8'h62, 8'h63, 8'h64, 8'hff, 8'h10};
      logic [7:0] v [10] = '{8'h00, 8'h02, 8'h30, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
      for (int i = 0; i < 10; i++) begin
         cfl_smb_host_inst.rd(a[i], rd);
         chk("reg_reset", {8'h00, v[i]}, {8'h00, rd});
      end
      chk("ref_assist_en", 16'h0001, 16'(ref_assist_en));
      chk("false_lock_det_en", 16'h0000, 16'(false_lock_det_en));
   endtask
   task automatic t_channel_gate;
      cfl_smb_host_inst.wr(8'h64, 8'h21);
      cfl_smb_host_inst.rd(8'h64, rd);
      chk("tol_unselected", 16'h00ff, {8'h00, rd});
      cfl_smb_host_inst.wr(8'hff, 8'h01);
      cfl_smb_host_inst.wr(8'h64, 8'h21);
      cfl_smb_host_inst.rd(8'h64, rd);
      chk("tol_selected", 16'h0021, {8'h00, rd});
   endtask
   task automatic t_standards;
      logic [7:0] e [4] = '{8'h00, 8'hb2, 8'h90, 8'hb3};
      cfl_smb_host_inst.configure(8'hf6, 160, 165, 8'h2f);
      for (int i = 0; i < 4; i++) begin
         cfl_smb_host_inst.rd(8'h60 + 8'(i), rd);
         chk("count_reg", {8'h00, e[i]}, {8'h00, rd});
      end
      // a master ack must move the read on to the next register
      cfl_smb_host_inst.rd2(8'h61, rd, rd_next);
      chk("burst_first", {8'h00, e[1]}, {8'h00, rd});
      chk("burst_second", {8'h00, e[2]}, {8'h00, rd_next});
      chk("false_lock_det_en", 16'h0000, 16'(false_lock_det_en));
      st(1'b0, 1'b0, 2'd3, 0);
      meas(12800 + 15);
      st(1'b1, 1'b0, 2'd3, 0);
      // leaving lock only falls back to measuring; the sweep resumes after
      meas(12800 + 16);
      st(1'b0, 1'b0, 2'd3, 0);
      meas(12800 + 16);
      st(1'b0, 1'b0, 2'd3, 1);
      repeat (63) meas(12800 + 16);
      st(1'b0, 1'b1, 2'd0, 0);
      meas(13200 + 3);
      st(1'b0, 1'b1, 2'd0, 1);
      meas(13200 - 2);
      st(1'b1, 1'b1, 2'd0, 1);
      signal_detect <= 1'b0;
      repeat (3) @(posedge clk);
      chk("lock_after_loss", 16'h0000, 16'(cdr_lock));
      meas(13200);
      chk("lock_no_signal", 16'h0000, 16'(cdr_lock));
      signal_detect <= 1'b1;
      meas(13200);
      chk("lock_signal_back", 16'h0001, 16'(cdr_lock));
   endtask
   task automatic t_range;
      cfl_smb_host_inst.configure(8'h08, 136, 136, 8'hff);
      chk("false_lock_det_en", 16'h0001, 16'(false_lock_det_en));
      st(1'b0, 1'b0, 2'd2, 0);
      meas(10880);
      st(1'b1, 1'b0, 2'd2, 0);
      cfl_smb_host_inst.wr(8'h61, 8'h2a);
      cfl_smb_host_inst.wr(8'h0a, 8'h0c);
      chk("cdr_in_reset", 16'h0001, 16'(cdr_in_reset));
      cfl_smb_host_inst.wr(8'h0a, 8'h00);
      chk("cdr_released", 16'h0000, 16'(cdr_in_reset));
      meas(10880);
      st(1'b0, 1'b0, 2'd2, 1);
      meas(12800);
      st(1'b1, 1'b0, 2'd2, 1);
   endtask
   task automatic t_ref_off;
      cfl_smb_host_inst.wr(8'h36, 8'h00);
      chk("ref_assist_en", 16'h0000, 16'(ref_assist_en));
      cfl_smb_host_inst.wr(8'h0a, 8'h0c);
      cfl_smb_host_inst.wr(8'h0a, 8'h00);
      meas(0);
      st(1'b0, 1'b1, 2'd2, 0);
   endtask
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // sized well above the roughly 13k cycles the scenarios need
   initial begin
      repeat (60000) @(posedge clk);
      n_mismatch++;
      tally_and_finish();
   end
   initial begin
      rst = 1'b1;
      signal_detect = 1'b1;
      meas_valid = 1'b0;
      meas_count = '0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset_values();
      t_channel_gate();
      t_standards();
      t_range();
      t_ref_off();
      chk("nack_count", 16'h0000, 16'(cfl_smb_host_inst.nacks));
      tally_and_finish();
   end
endmodule

//--- design/cfl_chk_if.sv
`timescale 1ns/1ps
interface cfl_chk_if #(parameter int CW = 15, parameter int TW = 4);
   logic [CW-1:0] expected;
   logic [CW-1:0] measured;
   logic [TW-1:0] tol;
   logic hit;
   modport chk (input expected, input measured, input tol, output hit);
   modport ctl (output expected, output measured, output tol, input hit);
endinterface

//--- design/cfl_count_check.sv
`timescale 1ns/1ps
module cfl_count_check (
   cfl_chk_if.chk chk
);
   logic [$bits(chk.expected)-1:0] diff;

   always_comb begin
      if (chk.measured > chk.expected) begin
         diff = chk.measured - chk.expected;
      end else begin
         diff = chk.expected - chk.measured;
      end
      chk.hit = diff <= {{($bits(chk.expected) - $bits(chk.tol)){1'b0}}, chk.tol};
   end
endmodule

//--- design/cfl_lock_setup.sv
// Behaviour
// - group zero count in group0_expected_count_low and group0_expected_count_high
// - top bit selects manually loaded count
// - group one count in group1_expected_count_low and group1_expected_count_high
// - two 4-bit tolerances from count_tolerance nibbles
// - range mode: fixed divider one, forceable
// - standards mode switches divider and group automatically
// - lock restarts when cdr reset bits release
// - lock acquired only when programmed-rate signal present
// - reference-usage field resets to 2'b11
// - reference mode tunes coarse capacitor automatically
// - rate nibble decodes per-group divider sets
// - groups may differ with equal dividers
// - reference calibrates and judges lock only
// - divider register bit 1 disables false-lock
`timescale 1ns/1ps
module cfl_lock_setup import cfl_pkg::*; #(
   parameter logic [6:0] SMB_ADDR = 7'h18,
   parameter int CHANNEL_ID = 0,
   parameter logic [CNT_WIDTH-1:0] INTERNAL_COUNT = DEFAULT_COUNT
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic sdc_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic signal_detect,
   input wire logic [CNT_WIDTH-1:0] meas_count,
   input wire logic meas_valid,
   output logic cdr_lock,
   output logic cdr_in_reset,
   output logic lock_group,
   output logic [1:0] divider_exp,
   output logic [CAP_WIDTH-1:0] coarse_vco_capacitor_setting,
   output logic false_lock_det_en,
   output logic ref_assist_en
);
   typedef struct packed {
      cfl_smb_state_t sm;
      logic [7:0] sh;
      logic [3:0] bitc;
      logic [7:0] ptr;
      logic rd;
      logic mack;
      logic sda_low;
      logic sdc_prev;
      logic sda_prev;
      logic [7:0] cdr_rst;
      logic [7:0] rate_std;
      logic [7:0] ref_use;
      logic [7:0] g0_lo;
      logic [7:0] g0_hi;
      logic [7:0] g1_lo;
      logic [7:0] g1_hi;
      logic [7:0] tol;
      logic [7:0] chan_sel;
      cfl_lock_state_t ls;
      logic lock;
      logic rst_prev;
      logic tune_start;
      logic tune_step;
   } cfl_state_t;

   cfl_state_t s_q, s_d;
   logic sdc_rise, sdc_fall, start_cond, stop_cond, chan_hit, in_reset;
   logic [7:0] rd_data;
   logic [3:0] rate_code, mask0, mask1, force_mask;
   logic [CNT_WIDTH-1:0] exp0, exp1;
   logic tune_group, cur_hit;

   cfl_chk_if #(.CW(CNT_WIDTH), .TW(TOL_W)) chk0 ();
   cfl_chk_if #(.CW(CNT_WIDTH), .TW(TOL_W)) chk1 ();

   cfl_count_check u_chk0 (
      .chk(chk0.chk)
   );
   cfl_count_check u_chk1 (
      .chk(chk1.chk)
   );

   // manual flag picks the loaded count, else the internal one
   assign exp0 = s_q.g0_hi[MANUAL_BIT] ? {s_q.g0_hi[MANUAL_BIT-1:0], s_q.g0_lo} : INTERNAL_COUNT;
   assign exp1 = s_q.g1_hi[MANUAL_BIT] ? {s_q.g1_hi[MANUAL_BIT-1:0], s_q.g1_lo} : INTERNAL_COUNT;
   assign chk0.expected = exp0;
   assign chk1.expected = exp1;
   assign chk0.measured = meas_count;
   assign chk1.measured = meas_count;
   assign chk0.tol = s_q.tol[TOL_G0_LSB +: TOL_W];
   assign chk1.tol = s_q.tol[TOL_G1_LSB +: TOL_W];

   assign rate_code = s_q.rate_std[RATE_MSB:RATE_LSB];
   assign force_mask = 4'(4'h1 << s_q.rate_std[FORCE_DIV_MSB:FORCE_DIV_LSB]);
   always_comb begin
      mask0 = cfl_div_set(rate_code, 1'b0);
      mask1 = cfl_div_set(rate_code, 1'b1);
      // unlisted codes run frequency-range mode: one divider, nominally 1
      if (mask0 == DIV_NONE) begin
         mask0 = force_mask;
         mask1 = force_mask;
      end
   end

   assign ref_assist_en = s_q.ref_use[REF_MODE_MSB:REF_MODE_LSB] == REF_MODE_AUTO;

   cfl_vco_tune #(.CAP_W(CAP_WIDTH)) u_tune (
      .clk(clk),
      .rst(rst),
      .restart(s_q.tune_start),
      .step(s_q.tune_step),
      .auto_cal(ref_assist_en),
      .mask0(mask0),
      .mask1(mask1),
      .cap(coarse_vco_capacitor_setting),
      .group(tune_group),
      .div_exp(divider_exp)
   );

   assign cur_hit = tune_group ? chk1.hit : chk0.hit;
   assign in_reset = |s_q.cdr_rst[CDR_RST_MSB:CDR_RST_LSB];

   assign sdc_rise = sdc_in && !s_q.sdc_prev;
   assign sdc_fall = !sdc_in && s_q.sdc_prev;
   assign start_cond = sdc_in && s_q.sdc_prev && s_q.sda_prev && !sda_in;
   assign stop_cond = sdc_in && s_q.sdc_prev && !s_q.sda_prev && sda_in;
   // channel registers only take writes for the selected channel
   assign chan_hit = s_q.chan_sel[CHANNEL_ID];

   always_comb begin
      case (s_q.ptr)
         ADDR_CDR_RESET: rd_data = s_q.cdr_rst;
         ADDR_RATE_STD: rd_data = s_q.rate_std;
         ADDR_REF_USE: rd_data = s_q.ref_use;
         ADDR_G0_LO: rd_data = s_q.g0_lo;
         ADDR_G0_HI: rd_data = s_q.g0_hi;
         ADDR_G1_LO: rd_data = s_q.g1_lo;
         ADDR_G1_HI: rd_data = s_q.g1_hi;
         ADDR_TOL: rd_data = s_q.tol;
         ADDR_CHAN_SEL: rd_data = s_q.chan_sel;
         default: rd_data = RD_UNMAPPED;
      endcase
   end

   always_comb begin
      s_d = s_q;
      s_d.sdc_prev = sdc_in;
      s_d.sda_prev = sda_in;
      s_d.tune_start = 1'b0;
      s_d.tune_step = 1'b0;

      // serial slave: sample on rising clock, drive on falling clock
      if (start_cond) begin
         s_d.sm = SM_ADDR;
         s_d.bitc = 4'h0;
         s_d.sda_low = 1'b0;
      end else if (stop_cond) begin
         s_d.sm = SM_IDLE;
         s_d.sda_low = 1'b0;
      end else begin
         case (s_q.sm)
            SM_ADDR, SM_CMD, SM_WDATA: begin
               if (sdc_rise) begin
                  s_d.sh = {s_q.sh[6:0], sda_in};
                  s_d.bitc = s_q.bitc + 4'h1;
               end else if (sdc_fall && s_q.bitc == 4'h8) begin
                  s_d.bitc = 4'h0;
                  s_d.sda_low = 1'b1;
                  if (s_q.sm == SM_ADDR) begin
                     s_d.rd = s_q.sh[0];
                     if (s_q.sh[7:1] == SMB_ADDR) begin
                        s_d.sm = SM_ACK_ADDR;
                     end else begin
                        s_d.sm = SM_IDLE;
                        s_d.sda_low = 1'b0;
                     end
                  end else if (s_q.sm == SM_CMD) begin
                     s_d.ptr = s_q.sh;
                     s_d.sm = SM_ACK_CMD;
                  end else begin
                     s_d.sm = SM_ACK_W;
                     s_d.ptr = s_q.ptr + 8'h1;
                     case (s_q.ptr)
                        ADDR_CHAN_SEL: s_d.chan_sel = s_q.sh;
                        ADDR_CDR_RESET: if (chan_hit) s_d.cdr_rst = s_q.sh;
                        ADDR_RATE_STD: if (chan_hit) s_d.rate_std = s_q.sh;
                        ADDR_REF_USE: if (chan_hit) s_d.ref_use = s_q.sh;
                        ADDR_G0_LO: if (chan_hit) s_d.g0_lo = s_q.sh;
                        ADDR_G0_HI: if (chan_hit) s_d.g0_hi = s_q.sh;
                        ADDR_G1_LO: if (chan_hit) s_d.g1_lo = s_q.sh;
                        ADDR_G1_HI: if (chan_hit) s_d.g1_hi = s_q.sh;
                        ADDR_TOL: if (chan_hit) s_d.tol = s_q.sh;
                        default: s_d.ptr = s_q.ptr + 8'h1;
                     endcase
                  end
               end
            end
            SM_ACK_ADDR, SM_ACK_CMD, SM_ACK_W: begin
               if (sdc_fall) begin
                  s_d.sda_low = 1'b0;
                  if (s_q.sm == SM_ACK_ADDR && s_q.rd) begin
                     s_d.sm = SM_RDATA;
                     s_d.sh = rd_data;
                     // pointer moves past the byte just loaded, so an ack fetches the next
                     s_d.ptr = s_q.ptr + 8'h1;
                     s_d.sda_low = ~rd_data[7];
                     s_d.bitc = 4'h1;
                  end else if (s_q.sm == SM_ACK_ADDR) begin
                     s_d.sm = SM_CMD;
                  end else begin
                     s_d.sm = SM_WDATA;
                  end
               end
            end
            SM_RDATA: begin
               if (sdc_fall) begin
                  if (s_q.bitc == 4'h8) begin
                     s_d.sda_low = 1'b0;
                     s_d.sm = SM_ACK_R;
                  end else begin
                     s_d.sh = {s_q.sh[6:0], 1'b0};
                     s_d.sda_low = ~s_q.sh[6];
                     s_d.bitc = s_q.bitc + 4'h1;
                  end
               end
            end
            SM_ACK_R: begin
               if (sdc_rise) begin
                  s_d.mack = !sda_in;
               end else if (sdc_fall) begin
                  // master nack ends the read; ack fetches the next byte
                  if (s_q.mack) begin
                     s_d.ptr = s_q.ptr + 8'h1;
                     s_d.sh = rd_data;
                     s_d.sda_low = ~rd_data[7];
                     s_d.sm = SM_RDATA;
                     s_d.bitc = 4'h1;
                  end else begin
                     s_d.sm = SM_IDLE;
                  end
               end
            end
            default: s_d.sm = SM_IDLE;
         endcase
      end

      // lock acquisition
      s_d.rst_prev = in_reset;
      if (in_reset) begin
         s_d.ls = LS_HOLD;
         s_d.lock = 1'b0;
      end else if (s_q.rst_prev) begin
         s_d.tune_start = 1'b1;
         s_d.ls = LS_MEASURE;
         s_d.lock = 1'b0;
      end else begin
         case (s_q.ls)
            LS_HOLD: s_d.ls = LS_MEASURE;
            LS_MEASURE: begin
               if (meas_valid && signal_detect) begin
                  if (cur_hit) begin
                     s_d.ls = LS_LOCKED;
                     s_d.lock = 1'b1;
                  end else begin
                     s_d.tune_step = 1'b1;
                  end
               end
            end
            LS_LOCKED: begin
               // lock is judged against the reference count, and dropped when signal detect falls
               if (!signal_detect || (meas_valid && !cur_hit)) begin
                  s_d.ls = LS_MEASURE;
                  s_d.lock = 1'b0;
               end
            end
            default: s_d.ls = LS_HOLD;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
         s_q.sm <= SM_IDLE;
         s_q.sdc_prev <= 1'b1;
         s_q.sda_prev <= 1'b1;
         s_q.cdr_rst <= RST_CDR_RESET;
         s_q.rate_std <= RST_RATE_STD;
         s_q.ref_use <= RST_REF_USE;
         s_q.g0_lo <= RST_COUNT;
         s_q.g0_hi <= RST_COUNT;
         s_q.g1_lo <= RST_COUNT;
         s_q.g1_hi <= RST_COUNT;
         s_q.tol <= RST_TOL;
         s_q.chan_sel <= RST_CHAN_SEL;
         s_q.ls <= LS_HOLD;
         s_q.rst_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   assign sda_out = 1'b0;
   assign sda_oe = s_q.sda_low;
   assign cdr_lock = s_q.lock;
   assign cdr_in_reset = in_reset;
   assign lock_group = tune_group;
   assign false_lock_det_en = !s_q.rate_std[FALSE_LOCK_DIS_BIT];
endmodule

//--- design/cfl_pkg.sv
package cfl_pkg;

   // register offsets
   localparam logic [7:0] ADDR_CDR_RESET = 8'h0a;
   localparam logic [7:0] ADDR_RATE_STD = 8'h2f;
   localparam logic [7:0] ADDR_REF_USE = 8'h36;
   localparam logic [7:0] ADDR_G0_LO = 8'h60;
   localparam logic [7:0] ADDR_G0_HI = 8'h61;
   localparam logic [7:0] ADDR_G1_LO = 8'h62;
   localparam logic [7:0] ADDR_G1_HI = 8'h63;
   localparam logic [7:0] ADDR_TOL = 8'h64;
   localparam logic [7:0] ADDR_CHAN_SEL = 8'hff;

   // reset values
   localparam logic [7:0] RST_CDR_RESET = 8'h00;
   localparam logic [7:0] RST_RATE_STD = 8'h02;
   localparam logic [7:0] RST_REF_USE = 8'h30;
   localparam logic [7:0] RST_COUNT = 8'h00;
   localparam logic [7:0] RST_TOL = 8'hff;
   localparam logic [7:0] RST_CHAN_SEL = 8'h00;
   localparam logic [7:0] RD_UNMAPPED = 8'h00;

   // field positions
   localparam int CDR_RST_LSB = 2;
   localparam int CDR_RST_MSB = 3;
   localparam int REF_MODE_LSB = 4;
   localparam int REF_MODE_MSB = 5;
   localparam logic [1:0] REF_MODE_AUTO = 2'h3;
   localparam int RATE_LSB = 4;
   localparam int RATE_MSB = 7;
   localparam int FORCE_DIV_LSB = 2;
   localparam int FORCE_DIV_MSB = 3;
   localparam int FALSE_LOCK_DIS_BIT = 1;
   localparam int MANUAL_BIT = 7;
   localparam int TOL_G0_LSB = 0;
   localparam int TOL_G1_LSB = 4;
   localparam int TOL_W = 4;

   // expected count: vco rate in gbps times this scale
   localparam int COUNT_SCALE = 1280;
   localparam int CNT_WIDTH = 15;
   localparam int CAP_WIDTH = 6;
   localparam logic [CNT_WIDTH-1:0] DEFAULT_COUNT = 15'(10 * COUNT_SCALE);

   // rate field codes; divider sets are masks of {8,4,2,1}
   localparam logic [3:0] STD_A = 4'h2;
   localparam logic [3:0] STD_B = 4'h3;
   localparam logic [3:0] STD_C = 4'h4;
   localparam logic [3:0] STD_D = 4'h6;
   localparam logic [3:0] STD_E = 4'ha;
   localparam logic [3:0] STD_F = 4'hb;
   localparam logic [3:0] STD_G = 4'hc;
   localparam logic [3:0] STD_ETH = 4'hf;
   localparam logic [3:0] DIV_124 = 4'h7;
   localparam logic [3:0] DIV_24 = 4'h6;
   localparam logic [3:0] DIV_1248 = 4'hf;
   localparam logic [3:0] DIV_2 = 4'h2;
   localparam logic [3:0] DIV_1 = 4'h1;
   localparam logic [3:0] DIV_8 = 4'h8;
   localparam logic [3:0] DIV_NONE = 4'h0;
   localparam logic [2:0] EXP_NONE = 3'h4;

   typedef enum logic [1:0] {
      LS_HOLD = 2'b00,
      LS_MEASURE = 2'b01,
      LS_LOCKED = 2'b10
   } cfl_lock_state_t;

   typedef enum logic [3:0] {
      SM_IDLE = 4'b0000,
      SM_ADDR = 4'b0001,
      SM_ACK_ADDR = 4'b0010,
      SM_CMD = 4'b0011,
      SM_ACK_CMD = 4'b0100,
      SM_WDATA = 4'b0101,
      SM_ACK_W = 4'b0110,
      SM_RDATA = 4'b0111,
      SM_ACK_R = 4'b1000
   } cfl_smb_state_t;

   // per-group divider set for a rate code; zero means frequency-range mode
   function automatic logic [3:0] cfl_div_set(input logic [3:0] code, input logic grp);
      logic [3:0] m;
      m = DIV_NONE;
      case (code)
         STD_A, STD_B: m = DIV_124;
         STD_C, STD_F: m = DIV_24;
         STD_D: m = DIV_1248;
         STD_E: m = DIV_2;
         STD_G: m = DIV_1;
         STD_ETH: m = grp ? DIV_1 : DIV_8;
         default: m = DIV_NONE;
      endcase
      return m;
   endfunction

   // lowest allowed divider exponent at or above from, EXP_NONE if none
   function automatic logic [2:0] cfl_next_exp(input logic [3:0] mask, input logic [2:0] from);
      logic [2:0] r;
      r = EXP_NONE;
      for (int i = 3; i >= 0; i--) begin
         if (mask[i] && 3'(i) >= from) begin
            r = 3'(i);
         end
      end
      return r;
   endfunction

endpackage

//--- design/cfl_vco_tune.sv
`timescale 1ns/1ps
module cfl_vco_tune import cfl_pkg::*; #(
   parameter int CAP_W = CAP_WIDTH
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic restart,
   input wire logic step,
   input wire logic auto_cal,
   input wire logic [3:0] mask0,
   input wire logic [3:0] mask1,
   output logic [CAP_W-1:0] cap,
   output logic group,
   output logic [1:0] div_exp
);
   typedef struct packed {
      logic [CAP_W-1:0] cap;
      logic group;
      logic [1:0] dexp;
   } cfl_tune_t;

   cfl_tune_t s_q, s_d;
   logic [2:0] n_same, n_other, n_first;
   logic [3:0] cur_mask, oth_mask;

   always_comb begin
      s_d = s_q;
      cur_mask = s_q.group ? mask1 : mask0;
      oth_mask = s_q.group ? mask0 : mask1;
      n_same = cfl_next_exp(cur_mask, 3'(s_q.dexp) + 3'h1);
      n_other = cfl_next_exp(oth_mask, 3'h0);
      n_first = cfl_next_exp(mask0, 3'h0);
      if (restart) begin
         s_d.cap = '0;
         s_d.group = 1'b0;
         s_d.dexp = (n_first == EXP_NONE) ? 2'h0 : n_first[1:0];
      end else if (step) begin
         // sweep the capacitor first, then the divider set, then the other group
         if (auto_cal && s_q.cap != {CAP_W{1'b1}}) begin
            s_d.cap = s_q.cap + 1'b1;
         end else begin
            s_d.cap = '0;
            if (n_same != EXP_NONE) begin
               s_d.dexp = n_same[1:0];
            end else begin
               s_d.group = ~s_q.group;
               s_d.dexp = (n_other == EXP_NONE) ? 2'h0 : n_other[1:0];
            end
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign cap = s_q.cap;
   assign group = s_q.group;
   assign div_exp = s_q.dexp;
endmodule
